// ==== design/pll_ssc_config_control.sv ====
/*
 * configuration and control of a three-pll synthesizer: vco range, divider mode,
 * bypass routing, spread modulation on the second pll, output slew and states,
 * and the two multi-function pins.
 * assumes configuration levels on the clk domain; the two pins are asynchronous.
 */
`default_nettype none

module pll_ssc_config_control #(
    parameter logic [pll_ssc_pkg::SWEEP_AW-1:0] HALF_SLOW_CYC = pll_ssc_pkg::SWEEP_HALF_SLOW_CYC,
    parameter logic [pll_ssc_pkg::SWEEP_AW-1:0] HALF_FAST_CYC = pll_ssc_pkg::SWEEP_HALF_FAST_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // pll and output configuration
    input wire pll_ssc_pkg::pll_cfg_s [pll_ssc_pkg::NUM_PLL-1:0] pll_cfg,
    input wire pll_ssc_pkg::ssc_cfg_s ssc_cfg,
    input wire pll_ssc_pkg::out_cfg_s [pll_ssc_pkg::NUM_OUT-1:0] out_cfg,
    input wire logic [3:0] control_function,
    input wire logic internal_clock_select,
    // multi-function pins
    input wire logic multifunction_pin_zero,
    input wire logic multifunction_pin_one,
    // pll and output status
    output pll_ssc_pkg::pll_stat_s [pll_ssc_pkg::NUM_PLL-1:0] pll_status,
    output pll_ssc_pkg::out_stat_s [pll_ssc_pkg::NUM_OUT-1:0] out_status,
    // spread modulation
    output logic ssc_mod_en,
    output logic signed [pll_ssc_pkg::OFS_W-1:0] ssc_offset,
    output logic ssc_vco_over,
    // device control
    output logic device_power_down,
    output logic clock_input_select,
    output logic address_mode,
    output logic slave_address_bit_zero,
    output logic slave_address_bit_one
);
    import pll_ssc_pkg::*;

    // one clock and one reset for every property below, generate blocks included
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic [1:0] pin_in;
    logic [1:0] pin_meta_r;
    logic [1:0] pin_mid_r;
    logic [1:0] pin_late_r;
    logic [1:0] pin_stable_r;

    assign pin_in = {multifunction_pin_one, multifunction_pin_zero};

    // three-stage sync; a level counts once the last two stages agree
    for (genvar g = 0; g < 2; g++) begin : g_pin
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pin_meta_r[g] <= 1'b0;
                pin_mid_r[g] <= 1'b0;
                pin_late_r[g] <= 1'b0;
                pin_stable_r[g] <= 1'b0;
            end else begin
                pin_meta_r[g] <= pin_in[g];
                pin_mid_r[g] <= pin_meta_r[g];
                pin_late_r[g] <= pin_mid_r[g];
                if (pin_mid_r[g] == pin_late_r[g]) begin
                    pin_stable_r[g] <= pin_late_r[g];
                end
            end
        end
    end

    logic ctl_addr;
    logic ctl_low;
    logic ctl_tri;
    logic ctl_pd;
    logic ctl_byp;
    logic ctl_clksel;

    // pin roles from the control-function field
    always_comb begin
        ctl_addr = control_function == CF_ADDR;
        ctl_low = !control_function[CF_S1_HI] && !pin_stable_r[1]
                  && !control_function[CF_S1_LO];
        ctl_tri = !control_function[CF_S1_HI] && !pin_stable_r[1]
                  && control_function[CF_S1_LO];
        ctl_pd = control_function[1:0] == S0F_PD && !pin_stable_r[0];
        ctl_byp = control_function[1:0] == S0F_BYP && !pin_stable_r[0];
        if (control_function[1:0] == S0F_CLKSEL) begin
            ctl_clksel = pin_stable_r[0];
        end else begin
            ctl_clksel = internal_clock_select;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            device_power_down <= 1'b0;
            clock_input_select <= 1'b0;
        end else begin
            device_power_down <= ctl_pd;
            clock_input_select <= ctl_clksel;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            address_mode <= 1'b0;
            slave_address_bit_zero <= 1'b0;
            slave_address_bit_one <= 1'b0;
        end else begin
            address_mode <= ctl_addr;
            slave_address_bit_zero <= ctl_addr && pin_stable_r[0];
            slave_address_bit_one <= ctl_addr && pin_stable_r[1];
        end
    end

    for (genvar i = 0; i < NUM_PLL; i++) begin : g_pll
        pll_stat_s stat_nxt;

        always_comb begin
            stat_nxt.high_speed = pll_cfg[i].vco_range_select;
            if (pll_cfg[i].pll_bypass || ctl_byp) begin
                stat_nxt.route = ROUTE_PLL_BYP;
            end else if (pll_cfg[i].vco_bypass_select) begin
                stat_nxt.route = ROUTE_VCO_BYP;
            end else begin
                stat_nxt.route = ROUTE_VCO;
            end
            stat_nxt.power_down = pll_cfg[i].vco_bypass_select || ctl_byp || ctl_pd;
            stat_nxt.frac_en = stat_nxt.route == ROUTE_VCO
                               && pll_cfg[i].vco_freq_mhz <= VCO_FRAC_LIMIT_MHZ;
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                pll_status[i] <= PLL_STAT_RST;
            end else begin
                pll_status[i] <= stat_nxt;
            end
        end

        frac_mode_a: assert property (
            (pll_cfg[i].vco_freq_mhz <= VCO_FRAC_LIMIT_MHZ && !pll_cfg[i].pll_bypass
             && !pll_cfg[i].vco_bypass_select && !ctl_byp) |=> pll_status[i].frac_en)
            else $error("fractional mode not enabled");
        frac_off_a: assert property (
            pll_cfg[i].vco_freq_mhz > VCO_FRAC_LIMIT_MHZ |=> !pll_status[i].frac_en)
            else $error("fractional mode above limit");
        vco_pd_a: assert property (
            pll_cfg[i].vco_bypass_select && !pll_cfg[i].pll_bypass && !ctl_byp
            |=> pll_status[i].power_down && pll_status[i].route == ROUTE_VCO_BYP)
            else $error("vco bypass not routed or powered down");
        pll_byp_a: assert property (
            pll_cfg[i].pll_bypass |=> pll_status[i].route == ROUTE_PLL_BYP)
            else $error("pll bypass not routed");
    end

    for (genvar j = 0; j < NUM_OUT; j++) begin : g_out
        out_stat_s ostat_nxt;

        always_comb begin
            if (ctl_pd) begin
                ostat_nxt.state = OUT_PD;
            end else if (ctl_tri) begin
                ostat_nxt.state = OUT_TRI;
            end else if (ctl_low || out_cfg[j].force_low) begin
                ostat_nxt.state = OUT_LOW;
            end else begin
                ostat_nxt.state = OUT_ACTIVE;
            end
            if (out_cfg[j].src > SRC_PLL3) begin
                ostat_nxt.src = SRC_INPUT;
            end else begin
                ostat_nxt.src = out_cfg[j].src;
            end
            ostat_nxt.ssc_sel = out_cfg[j].src == SRC_PLL2_SSC;
            ostat_nxt.slew = out_cfg[j].slew;
        end

        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                out_status[j] <= OUT_STAT_RST;
            end else begin
                out_status[j] <= ostat_nxt;
            end
        end

        ssc_path_a: assert property (
            out_status[j].ssc_sel == (out_status[j].src == SRC_PLL2_SSC))
            else $error("spread path mismatch");
        out_prio_a: assert property (
            ctl_tri && !ctl_pd |=> out_status[j].state == OUT_TRI)
            else $error("three-state priority lost");
        pd_wins_a: assert property (
            ctl_pd |=> out_status[j].state == OUT_PD && device_power_down)
            else $error("power-down priority lost");
    end

    ssc_cfg_s ssc_cfg_q_r;
    logic sweep_run;
    logic signed [OFS_W-1:0] sweep_hi;
    logic signed [OFS_W-1:0] sweep_lo;
    logic [OFS_W-1:0] sweep_span;
    logic [OFS_W-1:0] sweep_amt;
    logic [SWEEP_AW-1:0] sweep_half;

    // modulated output runs unless bypassed or the device is down
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ssc_cfg_q_r <= SSC_CFG_RST;
            ssc_mod_en <= 1'b0;
            ssc_vco_over <= 1'b0;
        end else begin
            ssc_cfg_q_r <= ssc_cfg;
            ssc_mod_en <= !ssc_cfg.bypass && !ctl_pd;
            ssc_vco_over <= !ssc_cfg.bypass
                            && pll_cfg[SSC_PLL].vco_freq_mhz > VCO_SSC_LIMIT_MHZ;
        end
    end

    // any setting change restarts the sweep on the carrier
    assign sweep_run = ssc_mod_en && ssc_cfg_q_r == ssc_cfg;

    always_comb begin
        if (ssc_cfg_q_r.down_mode) begin
            unique case (ssc_cfg_q_r.amount)
                2'h0: sweep_amt = AMT_D0;
                2'h1: sweep_amt = AMT_D1;
                2'h2: sweep_amt = AMT_D2;
                2'h3: sweep_amt = AMT_D3;
            endcase
            sweep_hi = '0;
            sweep_lo = -sweep_amt;
            sweep_span = sweep_amt;
        end else begin
            unique case (ssc_cfg_q_r.amount)
                2'h0: sweep_amt = AMT_C0;
                2'h1: sweep_amt = AMT_C1;
                2'h2: sweep_amt = AMT_C2;
                2'h3: sweep_amt = AMT_C2;
            endcase
            sweep_hi = sweep_amt;
            sweep_lo = -sweep_amt;
            sweep_span = {sweep_amt[OFS_W-2:0], 1'b0};
        end
        sweep_half = ssc_cfg_q_r.fast_rate ? HALF_FAST_CYC : HALF_SLOW_CYC;
    end

    // the offset applies to the second pll's modulated output only
    ssc_sweep #(
        .OW(OFS_W),
        .AW(SWEEP_AW)
    ) u_sweep (
        .clk(clk),
        .nrst(nrst),
        .run(sweep_run),
        .hi(sweep_hi),
        .lo(sweep_lo),
        .span(sweep_span),
        .half_cyc(sweep_half),
        .offset(ssc_offset),
        .dir_up()
    );

    ssc_low_a: assert property (
        ssc_cfg.bypass |=> !ssc_mod_en ##1 ssc_offset == '0)
        else $error("bypassed spread output not held low");
    center_bound_a: assert property (
        !ssc_cfg_q_r.down_mode |-> ssc_offset <= $signed(AMT_C2)
                                   && ssc_offset >= -$signed(AMT_C2))
        else $error("center spread out of range");
    down_bound_a: assert property (
        ssc_cfg_q_r.down_mode && $past(ssc_cfg_q_r.down_mode) |-> ssc_offset <= 0)
        else $error("down spread above carrier");
    sweep_step_a: assert property (
        $past(sweep_run) |-> ssc_offset - $past(ssc_offset) inside {-1, 0, 1})
        else $error("sweep jumped");
    clk_sel_a: assert property (
        control_function[1:0] == S0F_CLKSEL |=> clock_input_select == $past(pin_stable_r[0]))
        else $error("pin clock select wrong");
    int_sel_a: assert property (
        control_function[1:0] != S0F_CLKSEL
        |=> clock_input_select == $past(internal_clock_select))
        else $error("internal clock select wrong");
    addr_map_a: assert property (
        ctl_addr |=> address_mode && slave_address_bit_zero == $past(pin_stable_r[0])
                     && slave_address_bit_one == $past(pin_stable_r[1]))
        else $error("address bits wrong");

    center_peak_c: cover property (!ssc_cfg_q_r.down_mode && ssc_offset == $signed(AMT_C2));
    down_deep_c: cover property (ssc_cfg_q_r.down_mode && ssc_offset == -$signed(AMT_D0));
    addr_mode_c: cover property (address_mode && slave_address_bit_one);
    power_down_c: cover property (device_power_down);
endmodule // pll_ssc_config_control

`default_nettype wire

// ==== design/pll_ssc_pkg.sv ====
/*
 * shared constants, types and reset values of the pll and spread control block.
 * assumes a 250 mhz control clock; all configuration arrives as plain levels.
 */
`default_nettype none

package pll_ssc_pkg;
    localparam int NUM_PLL = 3;
    localparam int NUM_OUT = 6;
    localparam int SSC_PLL = 1;
    localparam int OFS_W = 10;
    localparam int SWEEP_AW = 14;

    // clock rate and sweep rates, figures as printed
    localparam int CLK_MHZ = 250;
    localparam int SWEEP_SLOW_KHZ = 30;
    localparam int SWEEP_FAST_KHZ = 60;
    // cycles in half a sweep period, rounded down
    localparam logic [SWEEP_AW-1:0] SWEEP_HALF_SLOW_CYC =
        SWEEP_AW'(CLK_MHZ * 1000 / (2 * SWEEP_SLOW_KHZ));
    localparam logic [SWEEP_AW-1:0] SWEEP_HALF_FAST_CYC =
        SWEEP_AW'(CLK_MHZ * 1000 / (2 * SWEEP_FAST_KHZ));

    // vco limits in mhz: 250 fractional, 167 with spreading
    localparam logic [8:0] VCO_FRAC_LIMIT_MHZ = 9'h0fa;
    localparam logic [8:0] VCO_SSC_LIMIT_MHZ = 9'h0a7;

    // first-stage switch source codes
    localparam logic [2:0] SRC_INPUT = 3'h0;
    localparam logic [2:0] SRC_PLL1 = 3'h1;
    localparam logic [2:0] SRC_PLL2 = 3'h2;
    localparam logic [2:0] SRC_PLL2_SSC = 3'h3;
    localparam logic [2:0] SRC_PLL3 = 3'h4;

    // spread amounts in units of 0.01 percent
    localparam logic [OFS_W-1:0] AMT_C0 = 10'h00a;
    localparam logic [OFS_W-1:0] AMT_C1 = 10'h019;
    localparam logic [OFS_W-1:0] AMT_C2 = 10'h028;
    localparam logic [OFS_W-1:0] AMT_D0 = 10'h064;
    localparam logic [OFS_W-1:0] AMT_D1 = 10'h096;
    localparam logic [OFS_W-1:0] AMT_D2 = 10'h0c8;
    localparam logic [OFS_W-1:0] AMT_D3 = 10'h12c;

    // control-function field: [3:2] second pin, [1:0] first pin
    localparam int CF_S1_HI = 3;
    localparam int CF_S1_LO = 2;
    localparam logic [3:0] CF_ADDR = 4'hf;
    localparam logic [1:0] S0F_PD = 2'h0;
    localparam logic [1:0] S0F_BYP = 2'h1;
    localparam logic [1:0] S0F_CLKSEL = 2'h2;

    typedef enum logic [1:0] {OUT_ACTIVE, OUT_LOW, OUT_TRI, OUT_PD} out_state_e;
    typedef enum logic [1:0] {ROUTE_VCO, ROUTE_VCO_BYP, ROUTE_PLL_BYP} pll_route_e;

    typedef struct packed {
        logic vco_range_select;
        logic vco_bypass_select;
        logic pll_bypass;
        logic [8:0] vco_freq_mhz;
    } pll_cfg_s;

    typedef struct packed {
        pll_route_e route;
        logic power_down;
        logic frac_en;
        logic high_speed;
    } pll_stat_s;

    typedef struct packed {
        logic bypass;
        logic down_mode;
        logic [1:0] amount;
        logic fast_rate;
    } ssc_cfg_s;

    typedef struct packed {
        logic [2:0] src;
        logic [1:0] slew;
        logic force_low;
    } out_cfg_s;

    typedef struct packed {
        out_state_e state;
        logic [2:0] src;
        logic ssc_sel;
        logic [1:0] slew;
    } out_stat_s;

    localparam pll_stat_s PLL_STAT_RST = '{route: ROUTE_VCO, power_down: 1'b0,
                                          frac_en: 1'b0, high_speed: 1'b0};
    localparam out_stat_s OUT_STAT_RST = '{state: OUT_TRI, src: SRC_INPUT,
                                          ssc_sel: 1'b0, slew: 2'h0};
    localparam ssc_cfg_s SSC_CFG_RST = '{bypass: 1'b1, down_mode: 1'b0,
                                        amount: 2'h0, fast_rate: 1'b0};
endpackage

`default_nettype wire

// ==== design/ssc_sweep.sv ====
/*
 * triangular sweep generator for the modulated pll output.
 * assumes bounds and span stay steady while run is high.
 */
`default_nettype none

module ssc_sweep #(
    parameter int OW = 10,
    parameter int AW = 14
) (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // sweep setting
    input wire logic run,
    input wire logic signed [OW-1:0] hi,
    input wire logic signed [OW-1:0] lo,
    input wire logic [OW-1:0] span,
    input wire logic [AW-1:0] half_cyc,
    // sweep state
    output logic signed [OW-1:0] offset,
    output logic dir_up
);
    localparam logic signed [OW-1:0] STEP_ONE = OW'(1);

    logic [AW-1:0] acc_r;
    logic [AW-1:0] acc_sum;
    logic step;

    // span steps spread evenly over half a sweep period
    assign acc_sum = acc_r + AW'(span);
    assign step = acc_sum >= half_cyc;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_r <= '0;
        end else if (!run) begin
            acc_r <= '0;
        end else if (step) begin
            acc_r <= acc_sum - half_cyc;
        end else begin
            acc_r <= acc_sum;
        end
    end

    // starts on the carrier and turns at each bound, so center mode averages to zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            offset <= '0;
            dir_up <= 1'b1;
        end else if (!run) begin
            offset <= '0;
            dir_up <= 1'b1;
        end else if (step) begin
            if (dir_up) begin
                if (offset >= hi) begin
                    dir_up <= 1'b0;
                    offset <= offset - STEP_ONE;
                end else begin
                    offset <= offset + STEP_ONE;
                end
            end else begin
                if (offset <= lo) begin
                    dir_up <= 1'b1;
                    offset <= offset + STEP_ONE;
                end else begin
                    offset <= offset - STEP_ONE;
                end
            end
        end
    end
endmodule // ssc_sweep

`default_nettype wire

// ==== verif/pin_host_model.sv ====
/*
 * model of the parties outside the block: drives the two multi-function pins.
 * assumes the bench asks for pin levels; pins move off the clock, unrelated to it.
 */
`default_nettype none

module pin_host_model (
    // requested levels
    input wire logic want0,
    input wire logic want1,
    // pins
    output wire logic pin0,
    output wire logic pin1
);
    timeunit 1ns;
    timeprecision 100ps;
    // pins are asynchronous to clk, so they land mid-cycle
    assign #1.3 pin0 = want0;
    assign #1.3 pin1 = want1;
endmodule // pin_host_model

`default_nettype wire

// ==== verif/tb_pll_ssc_config_control.sv ====
/*
 * self-checking bench of the pll and spread control block.
 * assumes the package constants and shortened half sweep periods of 40 and 20 cycles.
 */
`default_nettype none

module tb_pll_ssc_config_control;
    timeunit 1ns;
    timeprecision 100ps;
    import pll_ssc_pkg::*;
    localparam logic [SWEEP_AW-1:0] HS = 14'h0028;
    localparam logic [SWEEP_AW-1:0] HF = 14'h0014;
    typedef struct packed {logic sel; logic [69:0] v;} note_s;
    logic clk, nrst, ics, w0, w1, p0, p1;
    logic mod_en, vco_over, dpd, cis, am, a0, a1, bad, trk_clr;
    pll_cfg_s [NUM_PLL-1:0] pcfg;
    ssc_cfg_s scfg;
    out_cfg_s [NUM_OUT-1:0] ocfg;
    logic [3:0] cf;
    pll_stat_s [NUM_PLL-1:0] pst;
    out_stat_s [NUM_OUT-1:0] ost;
    logic signed [OFS_W-1:0] ofs, mn, mx, prv;
    logic [OFS_W-1:0] ca[4] = '{AMT_C0, AMT_C1, AMT_C2, AMT_C2};
    logic [OFS_W-1:0] da[4] = '{AMT_D0, AMT_D1, AMT_D2, AMT_D3};
    int failures, cmp_count;
    note_s q[$];
    event ev;

    pll_ssc_config_control #(.HALF_SLOW_CYC(HS), .HALF_FAST_CYC(HF)) dut (
        .clk(clk), .nrst(nrst), .pll_cfg(pcfg), .ssc_cfg(scfg), .out_cfg(ocfg),
        .control_function(cf), .internal_clock_select(ics),
        .multifunction_pin_zero(p0), .multifunction_pin_one(p1),
        .pll_status(pst), .out_status(ost), .ssc_mod_en(mod_en), .ssc_offset(ofs),
        .ssc_vco_over(vco_over), .device_power_down(dpd), .clock_input_select(cis),
        .address_mode(am), .slave_address_bit_zero(a0), .slave_address_bit_one(a1));

    pin_host_model u_pins (.want0(w0), .want1(w1), .pin0(p0), .pin1(p1));

    function automatic logic [69:0] obs(logic sel);
        if (sel)
            return 70'({mn, mx, bad});
        return {pst, ost, mod_en, vco_over, dpd, cis, am, a0, a1};
    endfunction

    function automatic logic [69:0] model();
        pll_stat_s [NUM_PLL-1:0] ep;
        out_stat_s [NUM_OUT-1:0] eo;
        logic ad, pd, byp, tri_s, low_s;
        ad = (cf == CF_ADDR);
        pd = !ad && cf[1:0] == S0F_PD && !w0;
        byp = !ad && cf[1:0] == S0F_BYP && !w0;
        tri_s = !ad && cf[3:2] == 2'h1 && !w1;
        low_s = !ad && cf[3:2] == 2'h0 && !w1;
        for (int i = 0; i < NUM_PLL; i++) begin
            ep[i].route = (byp || pcfg[i].pll_bypass) ? ROUTE_PLL_BYP :
                pcfg[i].vco_bypass_select ? ROUTE_VCO_BYP : ROUTE_VCO;
            ep[i].power_down = pd || byp || pcfg[i].vco_bypass_select;
            ep[i].frac_en = ep[i].route == ROUTE_VCO &&
                pcfg[i].vco_freq_mhz <= VCO_FRAC_LIMIT_MHZ;
            ep[i].high_speed = pcfg[i].vco_range_select;
        end
        for (int i = 0; i < NUM_OUT; i++) begin
            eo[i].state = pd ? OUT_PD : tri_s ? OUT_TRI :
                (low_s || ocfg[i].force_low) ? OUT_LOW : OUT_ACTIVE;
            eo[i].src = ocfg[i].src > SRC_PLL3 ? SRC_INPUT : ocfg[i].src;
            eo[i].ssc_sel = ocfg[i].src == SRC_PLL2_SSC;
            eo[i].slew = ocfg[i].slew;
        end
        return {ep, eo, !scfg.bypass && !pd,
            !scfg.bypass && pcfg[SSC_PLL].vco_freq_mhz > VCO_SSC_LIMIT_MHZ, pd,
            (cf[1:0] == S0F_CLKSEL && !ad) ? w0 : ics,
            ad, ad && w0, ad && w1};
    endfunction

    task automatic note(logic sel, logic [69:0] v);
        q.push_back({sel, v});
        -> ev;
    endtask

    task automatic apply(int waitc);
        repeat (waitc) @(posedge clk);
        @(negedge clk);
        note(1'b0, model());
    endtask

    task automatic sweep(logic dn, logic [1:0] amt, logic byp);
        logic signed [OFS_W-1:0] a;
        a = dn ? da[amt] : ca[amt];
        scfg = '{bypass: byp, down_mode: dn, amount: amt, fast_rate: 1'($urandom)};
        trk_clr = 1'b1;
        repeat (4) @(negedge clk);
        trk_clr = 1'b0;
        repeat (1400) @(negedge clk);
        note(1'b1, 70'({byp ? 10'sh000 : -a, (byp || dn) ? 10'sh000 : a, 1'b0}));
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // sweep extremes and step size since the last clear
    always @(posedge clk) begin
        if (trk_clr) begin
            mn <= ofs;
            mx <= ofs;
            bad <= 1'b0;
        end else begin
            if (ofs < mn)
                mn <= ofs;
            if (ofs > mx)
                mx <= ofs;
            if (ofs - prv > 1 || prv - ofs > 1)
                bad <= 1'b1;
        end
        prv <= ofs;
    end

    initial begin
        forever begin
            @(ev);
            cmp_count++;
            if (obs(q[0].sel) !== q[0].v) begin
                failures++;
                $display("MISMATCH t=%0t exp=%h got=%h", $time, q[0].v, obs(q[0].sel));
            end
            void'(q.pop_front());
        end
    end

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #150000;
        failures++;
        end_of_test();
    end

    initial begin
        nrst = 1'b0;
        pcfg = '0;
        scfg = SSC_CFG_RST;
        ocfg = '0;
        cf = 4'h3;
        {ics, w0, w1, trk_clr} = 4'b0111;
        void'($urandom(32'h12623ac5));
        repeat (6) @(negedge clk);
        note(1'b0, {{NUM_PLL{PLL_STAT_RST}}, {NUM_OUT{OUT_STAT_RST}}, 7'h00});
        nrst = 1'b1;
        // pins need five edges, four through the sync and one into the output registers, before the outputs follow them
        repeat (6) @(negedge clk);
        $display("test reset done");
        repeat (200) begin
            for (int i = 0; i < NUM_PLL; i++) begin
                pcfg[i] = 12'($urandom);
                if (pcfg[i].pll_bypass)
                    pcfg[i].vco_bypass_select = 1'b0;
                if ($urandom_range(1))
                    pcfg[i].vco_freq_mhz = (i == SSC_PLL ? 9'h0a6 : 9'h0f9) +
                        9'($urandom_range(2));
            end
            ocfg = 36'({$urandom, $urandom});
            scfg.bypass = 1'($urandom);
            ics = 1'($urandom);
            apply(1);
        end
        $display("test pll and output config done");
        for (int i = 0; i < NUM_PLL; i++)
            pcfg[i] = '{1'b0, 1'b0, 1'b0, 9'h12c};
        scfg.bypass = 1'b1;
        for (int c = 0; c < 16; c++) begin
            for (int p = 0; p < 4; p++) begin
                cf = c[3:0];
                {w1, w0} = p[1:0];
                ics = 1'($urandom);
                ocfg = 36'({$urandom, $urandom});
                apply(6);
            end
        end
        $display("test pin roles done");
        cf = 4'h3;
        {w1, w0} = 2'b11;
        pcfg[SSC_PLL].vco_freq_mhz = 9'h096;
        for (int k = 0; k < 8; k++)
            sweep(k[2], k[1:0], 1'b0);
        sweep(1'b0, 2'h0, 1'b1);
        $display("test spread sweep done");
        @(negedge clk);
        end_of_test();
    end
endmodule // tb_pll_ssc_config_control

`default_nettype wire
